/* design/irq_pad_drive.sv */
// one interrupt pad driver: polarity and push-pull or open-drain stage
`timescale 1ns/10ps
`default_nettype none
module irq_pad_drive
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic irq_req,
  input wire logic polarity_high,
  input wire logic open_drain,
  output logic pad_o,
  output logic pad_oe
);
  logic pad_o_nxt;
  logic pad_oe_nxt;

  always_comb
  begin
    // asserted level follows polarity
    pad_o_nxt = irq_req ~^ polarity_high;
    // open drain only drives the asserted level, else releases the line
    pad_oe_nxt = open_drain ? irq_req : 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pad_o <= 1'b1;
      pad_oe <= 1'b1;
    end
    else
    begin
      pad_o <= pad_o_nxt;
      pad_oe <= pad_oe_nxt;
    end
  end

  chk_od_release: assert property (@(posedge mclk) disable iff (reset)
    open_drain && !irq_req |=> !pad_oe)
    else $error("open-drain pad driven while idle");
  chk_pp_drive: assert property (@(posedge mclk) disable iff (reset)
    !open_drain |=> pad_oe)
    else $error("push-pull pad not driven");
  chk_polarity_level: assert property (@(posedge mclk) disable iff (reset)
    irq_req |=> pad_o == $past(polarity_high))
    else $error("asserted interrupt level wrong");
endmodule
`default_nettype wire

/* design/wake_and_pin_config.sv */
// configuration register for wake sources, FIFO gating and interrupt pads
`timescale 1ns/10ps
`default_nettype none
module wake_and_pin_config
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic auto_sleep_enable,
  input wire logic sleep_request,
  input wire logic [3:0] detect_irq,
  input wire logic sample_valid,
  input wire logic fifo_empty,
  input wire logic irq_a_req,
  input wire logic irq_b_req,
  output logic sleeping,
  output logic wake_event,
  output logic [3:0] sleep_detect_enable,
  output logic fifo_flush,
  output logic sample_accept,
  output logic gate_overrun_flag,
  output logic irq_pin_a_o,
  output logic irq_pin_a_oe,
  output logic irq_pin_b_o,
  output logic irq_pin_b_oe
);
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [7:0] rdata_nxt;
  logic hit_nxt;
  logic sleeping_nxt;
  logic wake_nxt;
  logic [3:0] sden_nxt;
  logic flush_nxt;
  logic gated_r;
  logic gated_nxt;
  logic accept_nxt;
  logic gerr_nxt;
  logic transition;
  logic [3:0] wake_mask;
  logic sel;

  always_comb
  begin
    sel = reg_addr == wake_cfg_pkg::CFG_OFFSET;
    cfg_nxt = cfg_r;
    if (reg_wr && sel)
      cfg_nxt = reg_wdata & wake_cfg_pkg::CFG_WRITE_MASK;
    rdata_nxt = 8'h00;
    if (reg_rd && sel)
      rdata_nxt = cfg_r & wake_cfg_pkg::CFG_WRITE_MASK;
    hit_nxt = (reg_rd || reg_wr) && sel;
  end

  // gate the per-source wake masks out of the register
  genvar g;
  generate
    for (g = 0; g < wake_cfg_pkg::NUM_WAKE_SRC; g++)
    begin : g_wake
      assign wake_mask[g] = cfg_r[wake_cfg_pkg::WAKE_SRC_LSB + g];
    end
  endgenerate

  always_comb
  begin
    sleeping_nxt = sleeping;
    wake_nxt = 1'b0;
    // bypassed detectors are turned off while asleep
    sden_nxt = sleeping ? wake_mask : 4'hF;
    if (!auto_sleep_enable)
      sleeping_nxt = 1'b0;
    else if (!sleeping && sleep_request)
      sleeping_nxt = 1'b1;
    else if (sleeping && |(detect_irq & wake_mask))
    begin
      sleeping_nxt = 1'b0;
      wake_nxt = 1'b1;
    end
    if (sleeping_nxt)
      sden_nxt = wake_mask;
    transition = sleeping_nxt != sleeping;
  end

  always_comb
  begin
    flush_nxt = 1'b0;
    gated_nxt = gated_r;
    if (transition && !cfg_r[wake_cfg_pkg::BIT_GATE])
      flush_nxt = 1'b1;
    else if (transition && !fifo_empty)
      gated_nxt = 1'b1;
    // a mode change with the gate bit set keeps an existing hold even when the FIFO is empty
    if (fifo_empty && !(transition && cfg_r[wake_cfg_pkg::BIT_GATE]))
      gated_nxt = 1'b0;
    accept_nxt = sample_valid && !gated_nxt;
    // error tracks a sample meeting a held, still unemptied FIFO
    gerr_nxt = gate_overrun_flag;
    if (gated_r && sample_valid)
      gerr_nxt = 1'b1;
    if (!gated_nxt)
      gerr_nxt = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cfg_r <= wake_cfg_pkg::CFG_RESET;
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
      sleeping <= 1'b0;
      wake_event <= 1'b0;
      sleep_detect_enable <= 4'hF;
      fifo_flush <= 1'b0;
      gated_r <= 1'b0;
      sample_accept <= 1'b0;
      gate_overrun_flag <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      reg_rdata <= rdata_nxt;
      reg_hit <= hit_nxt;
      sleeping <= sleeping_nxt;
      wake_event <= wake_nxt;
      sleep_detect_enable <= sden_nxt;
      fifo_flush <= flush_nxt;
      gated_r <= gated_nxt;
      sample_accept <= accept_nxt;
      gate_overrun_flag <= gerr_nxt;
    end
  end

  irq_pad_drive pad_a
  (
    .mclk(mclk),
    .reset(reset),
    .irq_req(irq_a_req),
    .polarity_high(cfg_r[wake_cfg_pkg::BIT_POLARITY]),
    .open_drain(cfg_r[wake_cfg_pkg::BIT_DRIVE]),
    .pad_o(irq_pin_a_o),
    .pad_oe(irq_pin_a_oe)
  );

  irq_pad_drive pad_b
  (
    .mclk(mclk),
    .reset(reset),
    .irq_req(irq_b_req),
    .polarity_high(cfg_r[wake_cfg_pkg::BIT_POLARITY]),
    .open_drain(cfg_r[wake_cfg_pkg::BIT_DRIVE]),
    .pad_o(irq_pin_b_o),
    .pad_oe(irq_pin_b_oe)
  );

  // mode change: flush when hold is clear, otherwise keep the contents
  chk_flush_on_mode: assert property (@(posedge mclk) disable iff (reset)
    $changed(sleeping) && !$past(cfg_r[wake_cfg_pkg::BIT_GATE]) |-> fifo_flush)
    else $error("mode change without flush");
  chk_flush_only_mode: assert property (@(posedge mclk) disable iff (reset)
    fifo_flush |-> $changed(sleeping))
    else $error("flush without mode change");
  chk_hold_entered: assert property (@(posedge mclk) disable iff (reset)
    transition && cfg_r[wake_cfg_pkg::BIT_GATE] && !fifo_empty |=> gated_r && !fifo_flush)
    else $error("hold not entered on mode change");
  chk_gate_drops: assert property (@(posedge mclk) disable iff (reset)
    gated_r && sample_valid && !fifo_empty |=> !sample_accept)
    else $error("sample accepted while gated");
  chk_accept_open: assert property (@(posedge mclk) disable iff (reset)
    sample_valid && !gated_r && !transition |=> sample_accept)
    else $error("sample dropped while not gated");

  // the error flag only follows a sample that met a held buffer
  chk_err_sets: assert property (@(posedge mclk) disable iff (reset)
    gated_r && sample_valid && !fifo_empty && cfg_r[wake_cfg_pkg::BIT_GATE]
    |=> gate_overrun_flag)
    else $error("gate error not set");
  chk_err_cause: assert property (@(posedge mclk) disable iff (reset)
    $rose(gate_overrun_flag) |-> $past(gated_r) && $past(sample_valid))
    else $error("gate error without a gated sample");
  chk_err_holds: assert property (@(posedge mclk) disable iff (reset)
    gate_overrun_flag && !fifo_empty |=> gate_overrun_flag)
    else $error("gate error dropped before emptying");
  chk_err_clears: assert property (@(posedge mclk) disable iff (reset)
    fifo_empty && !transition |=> !gated_r && !gate_overrun_flag)
    else $error("gate error not cleared");

  chk_no_sleep_off: assert property (@(posedge mclk) disable iff (reset)
    !auto_sleep_enable |=> !sleeping)
    else $error("asleep without auto-sleep");
  chk_wake_masked: assert property (@(posedge mclk) disable iff (reset)
    sleeping && auto_sleep_enable && !sleep_request && (detect_irq & cfg_r[6:3]) == 4'h0
    |=> sleeping)
    else $error("woken by bypassed source");
  chk_wake_taken: assert property (@(posedge mclk) disable iff (reset)
    sleeping && auto_sleep_enable && |(detect_irq & cfg_r[6:3]) |=> !sleeping && wake_event)
    else $error("enabled source did not wake");
  chk_sleep_dets: assert property (@(posedge mclk) disable iff (reset)
    sleeping |-> sleep_detect_enable == $past(cfg_r[6:3]))
    else $error("detector enables differ from wake mask");
  chk_awake_dets: assert property (@(posedge mclk) disable iff (reset)
    !sleeping && !$past(sleeping) |-> sleep_detect_enable == 4'hF)
    else $error("detector bypassed while awake");

  chk_cfg_write: assert property (@(posedge mclk) disable iff (reset)
    reg_wr && reg_addr == wake_cfg_pkg::CFG_OFFSET
    |=> cfg_r == ($past(reg_wdata) & wake_cfg_pkg::CFG_WRITE_MASK))
    else $error("register write not stored");
  chk_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
    reg_hit && !$past(reg_wr) |-> !reg_rdata[2])
    else $error("reserved bit read nonzero");

  cov_sleep_entry: cover property (@(posedge mclk) disable iff (reset) $rose(sleeping));
  cov_flush: cover property (@(posedge mclk) disable iff (reset) fifo_flush);
  cov_gate_err: cover property (@(posedge mclk) disable iff (reset) gate_overrun_flag);
  cov_wake: cover property (@(posedge mclk) disable iff (reset) wake_event);
endmodule
`default_nettype wire

/* design/wake_cfg_pkg.sv */
// constants for the wake source and interrupt pin configuration block
// Behaviour
// - gate clear: flush FIFO on mode change
// - gate set: hold FIFO, drop new samples
// - unemptied FIFO at next sample sets error
// - error stays until host empties FIFO
// - bit 6 lets transient wake SLEEP
// - bit 5 lets orientation wake SLEEP
// - bit 4 lets pulse wake SLEEP
// - bit 3 lets freefall/motion wake SLEEP
// - bit 1 selects interrupt pin polarity
// - bit 0 selects push-pull or open-drain
// - sleep and wake by a source only with auto-sleep enable; clearing it forces wake
package wake_cfg_pkg;
  localparam logic [7:0] CFG_OFFSET = 8'h2C;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hFB;
  localparam int BIT_GATE = 7;
  localparam int BIT_WAKE_FROM_TRANSIENT = 6;
  localparam int BIT_WAKE_ORIENT = 5;
  localparam int BIT_WAKE_PULSE = 4;
  localparam int BIT_WAKE_FFMT = 3;
  localparam int BIT_POLARITY = 1;
  localparam int BIT_DRIVE = 0;
  localparam int WAKE_SRC_LSB = 3;
  localparam int NUM_WAKE_SRC = 4;
endpackage

/* testbench/fifo_host_model.sv */
// far side model: fifo fill level and wired interrupt line
`timescale 1ns/10ps
`default_nettype none
module fifo_host_model
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic sample_accept,
  input wire logic fifo_flush,
  input wire logic drain,
  input wire logic pad_o,
  input wire logic pad_oe,
  output logic fifo_empty,
  output logic irq_line
);
  logic [5:0] level_r;
  // a released line falls back to the pull-up level, never the last value
  assign irq_line = pad_oe ? pad_o : 1'b1;
  assign fifo_empty = (level_r == 6'h00);
  always_ff @(posedge mclk)
  begin
    if (reset || fifo_flush || drain)
      level_r <= 6'h00;
    else if (sample_accept)
      level_r <= level_r + 6'h01;
  end
endmodule
`default_nettype wire

/* testbench/test_wake_and_pin_config.sv */
// self-checking bench for the wake and interrupt pin configuration register
`timescale 1ns/10ps
`default_nettype none
module test_wake_and_pin_config;
  logic mclk = 0, reset = 1, wr = 0, rd = 0, ase = 0, sreq = 0, sv = 0, drain = 0;
  logic ia = 0, ib = 0, empty, line, ao, aoe, bo, boe, slp, flush, acc, flag, wk;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [3:0] det = 4'h0, sden;
  logic hit;
  int n_errors = 0, samples_checked = 0, n_flush = 0, n_acc = 0, n_wake = 0;
  always #4 mclk = ~mclk;
  // pulses are counted mid-cycle, where the registered outputs have settled
  always @(negedge mclk)
  begin
    n_flush += flush;
    n_acc += acc;
    n_wake += wk;
  end
  wake_and_pin_config dut_u (.mclk(mclk), .reset(reset), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit),
    .auto_sleep_enable(ase), .sleep_request(sreq), .detect_irq(det), .sample_valid(sv),
    .fifo_empty(empty), .irq_a_req(ia), .irq_b_req(ib), .sleeping(slp), .wake_event(wk),
    .sleep_detect_enable(sden), .fifo_flush(flush), .sample_accept(acc),
    .gate_overrun_flag(flag), .irq_pin_a_o(ao), .irq_pin_a_oe(aoe), .irq_pin_b_o(bo),
    .irq_pin_b_oe(boe));
  fifo_host_model host_u (.mclk(mclk), .reset(reset), .sample_accept(acc),
    .fifo_flush(flush), .drain(drain), .pad_o(bo), .pad_oe(boe), .fifo_empty(empty),
    .irq_line(line));
  task automatic summarize;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(rdata, e);
    chk({7'h00, hit}, {7'h00, h});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic pulse_sample;
    @(posedge mclk);
    sv <= 1'b1;
    @(posedge mclk);
    sv <= 1'b0;
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    rreg(8'h2C, 8'h00, 1'b1);
    wreg(8'h2C, 8'hFF);
    rreg(8'h2C, 8'hFB, 1'b1);
    rreg(8'h2D, 8'h00, 1'b0);
    $display("test register done");
    @(posedge mclk);
    ia <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wreg(8'h2C, {6'h00, m[1:0]});
      wait_n(2);
      // pad b idles, so open drain must release it to the pull-up
      chk({3'h0, ao, aoe, bo, boe, line},
        {3'h0, m[1], 1'b1, !m[1], !m[0], m[0] | !m[1]});
    end
    // an asserted open-drain pad pulls the shared line low
    @(posedge mclk);
    ia <= 1'b0;
    ib <= 1'b1;
    wreg(8'h2C, 8'h01);
    wait_n(2);
    chk({3'h0, ao, aoe, bo, boe, line}, 8'h12);
    @(posedge mclk);
    ib <= 1'b0;
    $display("test pads done");
    wreg(8'h2C, 8'h08);
    repeat (3) pulse_sample;
    sreq <= 1'b1;
    wait_n(3);
    chk({7'h00, slp}, 8'h00);
    @(posedge mclk);
    ase <= 1'b1;
    wait_n(2);
    chk({3'h0, slp, sden}, 8'h11);
    @(posedge mclk);
    sreq <= 1'b0;
    det <= 4'h2;
    wait_n(3);
    chk({7'h00, slp}, 8'h01);
    @(posedge mclk);
    det <= 4'h1;
    wait_n(3);
    chk({3'h0, slp, sden}, 8'h0F);
    chk({6'h00, slp, empty}, 8'h01);
    chk({n_wake[3:0], n_flush[3:0]}, 8'h12);
    @(posedge mclk);
    det <= 4'h0;
    $display("test wake done");
    wreg(8'h2C, 8'h80);
    repeat (2) pulse_sample;
    sreq <= 1'b1;
    wait_n(3);
    @(posedge mclk);
    sreq <= 1'b0;
    n_acc = 0;
    pulse_sample;
    wait_n(3);
    chk({5'h00, slp, flag, empty}, 8'h06);
    chk({n_acc[3:0], n_flush[3:0]}, 8'h02);
    @(posedge mclk);
    drain <= 1'b1;
    @(posedge mclk);
    drain <= 1'b0;
    wait_n(3);
    chk({6'h00, flag, empty}, 8'h01);
    // dropping auto-sleep wakes without a wake pulse and, with hold set, without flush
    @(posedge mclk);
    ase <= 1'b0;
    wait_n(2);
    chk({3'h0, slp, n_wake[1:0], n_flush[1:0]}, 8'h06);
    $display("test gate done");
    summarize();
  end
  initial
  begin
    repeat (2000) @(posedge mclk);
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
